// *** core/nvcfg_latches.sv ***
// reset configuration latch array with decoded, reset-stable outputs
// assumes a single 125 MHz clock and two asynchronous active-low resets, rst_b and por_b
//
// Our own choice: the address-and-strobe port.
`default_nettype none
// Contract
// [R1] four config latch bytes are kept and their contents are applied whenever the device leaves reset.
// [R2] each port drive-mode field codes 00 hiz analog, 01 hiz digital, 10 pull up, 11 pull down.
// [R3] one port's drive mode is fanned out unchanged to all eight pins of that port.
// [R4] ext reset enable makes P1[2] a gpio at 0 and the external reset input at 1, default per package.
// [R5] debug enable blocks debug access at 0 and permits it at 1, default 1.
// [R6] ecc enable keeps the spare flash for ecc at 1, default 1, and frees it at 0.
// [R7] a two-bit field picks which port-1 pins form the debug port after reset.
// [R8] a four-bit field selects the digital clock phase delay.
// [R9] byte 0 holds ports 0-3, byte 1 ports 4,5,6,12, byte 2 port 15 plus ext reset and debug enables in bits 7 and 6.
// [R10] byte 3 holds phase delay, ecc and debug port select, and applied values are sampled once per reset.
module nvcfg_latches
	import nvcfg_pkg::*;
#(
	parameter bit PKG_48PIN = 1'b0
)
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	input  wire logic                  por_b,
	input  wire logic [2:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	output nvcfg_pkg::nvcfg_applied_t  cfg_applied,
	output logic      [143:0]          pin_reset_drive_mode,
	output logic                       cfg_valid
);
	import nvcfg_pkg::*;

	// ---------------------------------------------------------------
	// latch storage
	// ---------------------------------------------------------------
	// contents survive the logic reset: a nonvolatile cell is modelled
	// as storage loaded with factory values only on power-up reset
	logic [7:0] latch_q [NVCFG_NUM_BYTES];
	logic [7:0] latch_d [NVCFG_NUM_BYTES];
	logic [7:0] rdata_q;
	logic       applied_q;
	nvcfg_applied_t applied_q_s;
	logic [143:0] pin_mode_q;

	// the package straps only the external reset bit of byte 2
	localparam logic [7:0] BYTE2_DFLT = PKG_48PIN ?
		(NVCFG_BYTE2_RESET | 8'h80) : NVCFG_BYTE2_RESET; // R4
	wire logic       wr_latch    = reg_wr && (reg_addr[2] == 1'b0);
	wire logic [1:0] widx        = reg_addr[1:0];

	genvar gi;
	generate
		for (gi = 0; gi < NVCFG_NUM_BYTES; gi++)
		begin : g_latch
			localparam logic [7:0] LATCH_DFLT = (gi == 0) ? NVCFG_BYTE0_RESET :
				(gi == 1) ? NVCFG_BYTE1_RESET :
				(gi == 2) ? BYTE2_DFLT : NVCFG_BYTE3_RESET;
			assign latch_d[gi] = (wr_latch && widx == 2'(gi)) ? reg_wdata : latch_q[gi];
			always_ff @(posedge clk_sys or negedge por_b)
			begin
				if (!por_b)
					latch_q[gi] <= LATCH_DFLT;
				else
					latch_q[gi] <= latch_d[gi];
			end
		end
	endgenerate

	// marks the first edge after release; capture runs one edge behind it
	logic pkg_fix_q;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			pkg_fix_q <= 1'b0;
		else
			pkg_fix_q <= 1'b1;
	end

	// ---------------------------------------------------------------
	// field decode
	// ---------------------------------------------------------------
	wire logic [7:0] b0 = latch_q[0];
	wire logic [7:0] b1 = latch_q[1];
	wire logic [7:0] b2 = latch_q[2];
	wire logic [7:0] b3 = latch_q[3];
	// port order: 0,1,2,3,4,5,6,12,15
	wire logic [17:0] port_modes = {b2[1:0], b1, b0}; // R9
	wire nvcfg_applied_t decoded = '{
		port_reset_drive_mode:     port_modes,
		ext_reset_pin_enable:      b2[NVCFG_EXT_RESET_BIT],   // R4 R9
		debug_access_enable:       b2[NVCFG_DEBUG_EN_BIT],    // R5 R9
		flash_ecc_enable:          b3[NVCFG_ECC_BIT],         // R6 R10
		debug_port_select:         b3[NVCFG_DPS_LSB +: 2],    // R7 R10
		digital_clock_phase_delay: b3[NVCFG_PHASE_LSB +: 4]   // R8 R10
	};

	// R3: every pin of a port gets the port's two-bit mode
	logic [143:0] pin_mode_d;
	generate
		for (gi = 0; gi < NVCFG_NUM_PORTS * 8; gi++)
		begin : g_pin
			assign pin_mode_d[gi*2 +: 2] = port_modes[(gi/8)*2 +: 2]; // R3
		end
	endgenerate

	// ---------------------------------------------------------------
	// apply once per reset
	// ---------------------------------------------------------------
	// sampling on the second edge after release keeps later writes from
	// disturbing a running device; they take effect at the next reset
	wire logic take = pkg_fix_q && !applied_q;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			applied_q   <= 1'b0;
			applied_q_s <= '0;
			pin_mode_q  <= '0;
		end
		else if (take) // R1 R10
		begin
			applied_q   <= 1'b1;
			applied_q_s <= decoded;
			pin_mode_q  <= pin_mode_d;
		end
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	// addresses 5 to 7 are holes that read as zero
	wire logic       rd_is_latch  = (reg_addr[2] == 1'b0);
	wire logic       rd_is_status = (reg_addr == NVCFG_STATUS_ADDR);
	wire logic [7:0] status_byte  = {7'h00, applied_q};
	wire logic [7:0] rd_mux       = rd_is_latch ? latch_q[widx] :
		rd_is_status ? status_byte : 8'h00;
	wire logic [7:0] rdata_d      = reg_rd ? rd_mux : 8'h00;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata            = rdata_q;
	assign cfg_applied          = applied_q_s;
	assign pin_reset_drive_mode = pin_mode_q;
	assign cfg_valid            = applied_q;

	// ---------------------------------------------------------------
	// checks: capture
	// ---------------------------------------------------------------
	// a capture that slipped would let a later write reach a running part
	AST_APPLY_ONCE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
		applied_q
		|=> $stable(applied_q_s))
		else $error("applied config changed after capture");

	AST_APPLY_AT_RESET: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		$rose(pkg_fix_q)
		|=> cfg_valid)
		else $error("config not applied after reset");

	AST_VALID_WAITS: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		!pkg_fix_q
		|-> !cfg_valid)
		else $error("config valid before reset release settled");

	AST_NO_EARLY: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		$rose(pkg_fix_q)
		|-> !cfg_valid)
		else $error("config valid on the first edge after release");

	AST_VALID_STAYS: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
		cfg_valid
		|=> cfg_valid)
		else $error("config valid dropped without a reset");

	AST_TAKE_ONCE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
		take
		|=> !take)
		else $error("capture taken twice in one reset");

	AST_VALID_AFTER_TAKE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		$rose(cfg_valid)
		|-> $past(take))
		else $error("config valid rose without a capture");

	// outputs must read as zero until the capture, not as stale settings
	AST_QUIET_BEFORE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		!cfg_valid
		|-> (cfg_applied == '0) && (pin_reset_drive_mode == '0))
		else $error("config outputs active before capture");

	AST_PIN_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
		cfg_valid
		|=> $stable(pin_reset_drive_mode))
		else $error("pin drive modes changed after capture");

	AST_IGNORES_WRITES: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
		cfg_valid && reg_wr
		|=> $stable(cfg_applied))
		else $error("write reached the applied config");

	AST_CAPTURE_TRACKS: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		take
		|=> cfg_applied == $past(decoded))
		else $error("applied config is not the latch contents");

	// ---------------------------------------------------------------
	// checks: field placement
	// ---------------------------------------------------------------
	AST_EXT_RESET: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
		take
		|=> cfg_applied.ext_reset_pin_enable == $past(b2[7]))
		else $error("ext reset enable mismatch");

	AST_DEBUG_EN: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
		take
		|=> cfg_applied.debug_access_enable == $past(b2[6]))
		else $error("debug enable mismatch");

	AST_ECC_EN: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
		take
		|=> cfg_applied.flash_ecc_enable == $past(b3[2]))
		else $error("ecc enable mismatch");

	AST_DPS: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
		take
		|=> cfg_applied.debug_port_select == $past(b3[1:0]))
		else $error("debug port select mismatch");

	AST_PHASE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
		take
		|=> cfg_applied.digital_clock_phase_delay == $past(b3[7:4]))
		else $error("phase delay mismatch");

	AST_LAYOUT: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9 R2
		take
		|=> cfg_applied.port_reset_drive_mode[17:16] == $past(b2[1:0]))
		else $error("port 15 field misplaced");

	AST_LAYOUT_B0: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
		take
		|=> cfg_applied.port_reset_drive_mode[7:0] == $past(b0))
		else $error("ports 0 to 3 fields misplaced");

	AST_LAYOUT_B1: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
		take
		|=> cfg_applied.port_reset_drive_mode[15:8] == $past(b1))
		else $error("ports 4 to 12 fields misplaced");

	// ---------------------------------------------------------------
	// checks: pin fan-out
	// ---------------------------------------------------------------
	AST_PORT_UNIFORM: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
		cfg_valid
		|-> pin_reset_drive_mode[15:0] == {8{cfg_applied.port_reset_drive_mode[1:0]}})
		else $error("port pins differ in drive mode");

	// one copy per port, so a wrong stride in the fan-out shows at once
	genvar gp;
	generate
		for (gp = 0; gp < NVCFG_NUM_PORTS; gp++)
		begin : g_fanout
			AST_PIN_FANOUT: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
				cfg_valid
				|-> pin_reset_drive_mode[gp*16 +: 16] == {8{cfg_applied.port_reset_drive_mode[gp*2 +: 2]}})
				else $error("pin drive mode differs from its port");
		end
	endgenerate

	// ---------------------------------------------------------------
	// checks: register port
	// ---------------------------------------------------------------
	AST_RD_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		!reg_rd
		|=> reg_rdata == 8'h00)
		else $error("read data not zero without a read");

	AST_RD_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		reg_rd ##1 !reg_rd
		|=> reg_rdata == 8'h00)
		else $error("read data stood longer than one cycle");

	AST_RD_STATUS: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		reg_rd && reg_addr == NVCFG_STATUS_ADDR
		|=> reg_rdata == {7'h00, $past(cfg_valid)})
		else $error("status read does not show config valid");

	AST_STATUS_LOW: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		reg_rd && reg_addr == NVCFG_STATUS_ADDR && !cfg_valid
		|=> reg_rdata == 8'h00)
		else $error("status shows valid before capture");

	AST_RD_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
		reg_rd && reg_addr > NVCFG_STATUS_ADDR
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	// latch storage resets on por_b only, so its write checks disable on it; the read check disables on rst_b
	genvar gb;
	generate
		for (gb = 0; gb < NVCFG_NUM_BYTES; gb++)
		begin : g_bus_chk
			AST_RD_LATCH: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
				reg_rd && reg_addr == 3'(gb)
				|=> reg_rdata == $past(latch_q[gb]))
				else $error("read data is not the latch byte");

			AST_WR_LANDS: assert property (@(posedge clk_sys) disable iff (!por_b) // R1
				reg_wr && reg_addr == 3'(gb)
				|=> latch_q[gb] == $past(reg_wdata))
				else $error("write did not land in its latch byte");

			AST_WR_KEEPS: assert property (@(posedge clk_sys) disable iff (!por_b) // R10
				!(reg_wr && reg_addr == 3'(gb))
				|=> $stable(latch_q[gb]))
				else $error("latch byte changed without a write to it");
		end
	endgenerate
endmodule // nvcfg_latches
`default_nettype wire

// *** core/nvcfg_pkg.sv ***
// package for the reset configuration latch block
// assumes a single clock domain and a plain register port
`default_nettype none
package nvcfg_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [1:0] NVCFG_PORT_RESET_MODE_LOW   = 2'h0;
	localparam logic [1:0] NVCFG_PORT_RESET_MODE_MID   = 2'h1;
	localparam logic [1:0] NVCFG_RESET_PIN_DEBUG_CFG   = 2'h2;
	localparam logic [1:0] NVCFG_CLOCK_ECC_DEBUGPORT   = 2'h3;
	localparam logic [2:0] NVCFG_STATUS_ADDR           = 3'h4;
	localparam int         NVCFG_NUM_BYTES             = 4;
	localparam int         NVCFG_NUM_PORTS             = 9;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int NVCFG_EXT_RESET_BIT  = 7;
	localparam int NVCFG_DEBUG_EN_BIT   = 6;
	localparam int NVCFG_PHASE_LSB      = 4;
	localparam int NVCFG_ECC_BIT        = 2;
	localparam int NVCFG_DPS_LSB        = 0;

	// ---------------------------------------------------------------
	// factory defaults
	// ---------------------------------------------------------------
	localparam logic [7:0] NVCFG_BYTE0_RESET = 8'h00;
	localparam logic [7:0] NVCFG_BYTE1_RESET = 8'h00;
	localparam logic [7:0] NVCFG_BYTE2_RESET = 8'h40;
	localparam logic [7:0] NVCFG_BYTE3_RESET = 8'h04;

	typedef enum logic [1:0]
	{
		NVCFG_DRV_HIZ_ANALOG  = 2'h0,
		NVCFG_DRV_HIZ_DIGITAL = 2'h1,
		NVCFG_DRV_PULL_UP     = 2'h2,
		NVCFG_DRV_PULL_DOWN   = 2'h3
	} nvcfg_drive_mode_t;

	typedef struct packed
	{
		logic [17:0] port_reset_drive_mode;
		logic        ext_reset_pin_enable;
		logic        debug_access_enable;
		logic        flash_ecc_enable;
		logic [1:0]  debug_port_select;
		logic [3:0]  digital_clock_phase_delay;
	} nvcfg_applied_t;
endpackage
`default_nettype wire

// *** verification/nvcfg_latches_tb_top.sv ***
// self-checking bench for the reset configuration latch block
// assumes the 48-pin default is off, so byte 2 resets to 40
`default_nettype none
module nvcfg_latches_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import nvcfg_pkg::*;
	logic           clk_sys;
	logic           rst_b;
	logic           por_b;
	logic [2:0]     reg_addr;
	logic [7:0]     reg_wdata;
	logic           reg_wr;
	logic           reg_rd;
	logic [7:0]     reg_rdata;
	nvcfg_applied_t cfg_applied;
	nvcfg_applied_t dflt_cfg;
	logic [143:0]   pin_reset_drive_mode;
	logic           cfg_valid;
	logic [7:0]     rv;
	int             failures = 0;
	int             tests_run = 0;
	logic [7:0]     dflt [4] = '{8'h00, 8'h00, 8'h40, 8'h04};
	logic [7:0]     wv [4] = '{8'he4, 8'h1b, 8'ha5, 8'hf7};
	// drive modes that wv gives ports 0,1,2,3,4,5,6,12,15
	logic [1:0]     pm [9] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
	nvcfg_prog_model prog (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	nvcfg_latches #(.PKG_48PIN(1'b0)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .por_b(por_b),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cfg_applied(cfg_applied), .pin_reset_drive_mode(pin_reset_drive_mode), .cfg_valid(cfg_valid));
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task chk(input logic [143:0] got, input logic [143:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task do_reset();
		rst_b <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(cfg_valid, 0);
		chk(pin_reset_drive_mode, 0);
		rst_b <= 1'b1;
		por_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk(cfg_valid, 1);
	endtask
	task t_defaults();
		for (int a = 0; a < 4; a++)
		begin
			prog.rd(a[2:0], rv);
			chk(rv, dflt[a]);
		end
		chk(cfg_applied, dflt_cfg);
		chk(pin_reset_drive_mode, 0);
		prog.rd(3'h4, rv);
		chk(rv, 8'h01);
		$display("test defaults done");
	endtask
	// every drive-mode code lands in byte 0, but nothing is applied before a reset
	task t_write_hold();
		for (int a = 0; a < 4; a++)
			prog.wr(a[2:0], wv[a]);
		for (int a = 0; a < 4; a++)
		begin
			prog.rd(a[2:0], rv);
			chk(rv, wv[a]);
		end
		chk(cfg_applied, dflt_cfg);
		chk(pin_reset_drive_mode, 0);
		$display("test write hold done");
	endtask
	task t_unmapped();
		prog.wr(3'h4, 8'hfe);
		prog.rd(3'h4, rv);
		chk(rv, 8'h01);
		prog.rd(3'h5, rv);
		chk(rv, 8'h00);
		prog.rd(3'h7, rv);
		chk(rv, 8'h00);
		$display("test unmapped done");
	endtask
	// written bytes outlive rst_b, so the second capture applies them
	task t_rereset();
		nvcfg_applied_t exp_cfg;
		logic [143:0]   exp_pins;
		exp_cfg = '0;
		exp_pins = '0;
		for (int p = 0; p < 9; p++)
		begin
			exp_cfg.port_reset_drive_mode[p*2 +: 2] = pm[p];
			exp_pins[p*16 +: 16] = {8{pm[p]}};
		end
		exp_cfg.ext_reset_pin_enable = 1'b1;
		exp_cfg.debug_access_enable = 1'b0;
		exp_cfg.flash_ecc_enable = 1'b1;
		exp_cfg.debug_port_select = 2'h3;
		exp_cfg.digital_clock_phase_delay = 4'hf;
		do_reset();
		for (int a = 0; a < 4; a++)
		begin
			prog.rd(a[2:0], rv);
			chk(rv, wv[a]);
		end
		chk(cfg_applied, exp_cfg);
		chk(pin_reset_drive_mode, exp_pins);
		prog.rd(3'h4, rv);
		chk(rv, 8'h01);
		$display("test rereset done");
	endtask
	task give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		rst_b = 1'b0;
		por_b = 1'b0;
		dflt_cfg = '0;
		dflt_cfg.debug_access_enable = 1'b1;
		dflt_cfg.flash_ecc_enable = 1'b1;
		do_reset();
		t_defaults();
		t_write_hold();
		t_unmapped();
		t_rereset();
		give_verdict();
	end
	initial
	begin
		#200000;
		failures++;
		give_verdict();
	end
endmodule // nvcfg_latches_tb_top
`default_nettype wire

// *** verification/nvcfg_prog_model.sv ***
// programming interface model that writes and reads the config latch bytes
// assumes the bench owns clock and reset and calls wr and rd
`default_nettype none
module nvcfg_prog_model
(
	input  wire logic       clk_sys,
	output logic      [2:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// released data shows the inverse so a stale value cannot pass for a write
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule // nvcfg_prog_model
`default_nettype wire
